// ---- src/spc_pkg.sv ----
/*
   Shared constants of the sensor master-clock and PLL control block: register
   indices, byte addresses, field positions, reset values and bus answers.
   Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
*/
package spc_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0]  IDX_MASTER_CLOCK_CONFIG = 8'h65;
   localparam logic [7:0]  IDX_PLL_MULT_DIV        = 8'h66;
   localparam logic [11:0] ADDR_MASTER_CLOCK_CONFIG = {2'b00, IDX_MASTER_CLOCK_CONFIG, 2'b00};
   localparam logic [11:0] ADDR_PLL_MULT_DIV        = {2'b00, IDX_PLL_MULT_DIV, 2'b00};

   // master_clock_config fields
   localparam int BIT_PLL_BYPASS     = 15;
   localparam int BIT_PLL_POWERDOWN  = 14;
   localparam int BIT_STANDBY_PD     = 13;
   localparam int BIT_FORCE_ROW      = 2;
   localparam int BIT_FORCE_FRAME    = 1;
   localparam int BIT_FORCE_SHIP     = 0;
   localparam logic [15:0] CLK_CFG_MASK  = 16'hE007;
   localparam logic [15:0] CLK_CFG_RESET = 16'hE000;

   // pll_multiplier_divider fields
   localparam int MULT_LSB = 8;
   localparam int MULT_W   = 8;
   localparam int DIV_LSB  = 0;
   localparam int DIV_W    = 6;
   localparam logic [15:0] PLL_MD_MASK  = 16'hFF3F;
   localparam logic [15:0] PLL_MD_RESET = 16'h2809;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : spc_pkg

// ---- src/spc_clock_control.sv ----
/*
   Master-clock selection and PLL control of the image sensor, with its two
   configuration registers on an AXI4-Lite slave.
   Assumes all inputs are synchronous to aclk; the clock multiplexer, PLL and
   clock gates themselves sit outside and follow the level outputs here.
*/
module spc_clock_control
   import spc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write address
   input  wire logic                s_axi_awvalid,
   output      logic                s_axi_awready,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                s_axi_wvalid,
   output      logic                s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // AXI4-Lite write response
   output      logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output      logic [1:0]          s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                s_axi_arvalid,
   output      logic                s_axi_arready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   // AXI4-Lite read data
   output      logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output      logic [31:0]         s_axi_rdata,
   output      logic [1:0]          s_axi_rresp,
   // Sensor state and clock-gate requests
   input  wire logic                standby,
   input  wire logic                row_clk_req,
   input  wire logic                frame_clk_req,
   input  wire logic                ship_clk_req,
   // Clock control outputs
   output      logic                master_clk_use_pll,
   output      logic                pll_powerdown,
   output      logic                row_clk_en,
   output      logic                frame_clk_en,
   output      logic                ship_clk_en,
   output      logic [MULT_W-1:0]   pll_multiplier,
   output      logic [DIV_W-1:0]    pll_divider
);

   // Decoding must reach both register addresses
   if (ADDR_W < 12 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("spc_clock_control: ADDR_W must lie in 12..32");
   end

   // Word decode: 0 none, 1 clock config, 2 PLL multiplier/divider
   function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] word;
      word = {addr[ADDR_W-1:2], 2'b00};
      if (word == ADDR_W'(ADDR_MASTER_CLOCK_CONFIG))
         return 2'd1;
      else if (word == ADDR_W'(ADDR_PLL_MULT_DIV))
         return 2'd2;
      else
         return 2'd0;
   endfunction : decode

   // Byte-lane merge of a 16-bit register with writable mask
   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd,
                                         input logic [3:0] st, input logic [15:0] mask);
      logic [15:0] v;
      v = old_v;
      if (st[0])
         v[7:0] = wd[7:0];
      if (st[1])
         v[15:8] = wd[15:8];
      return v & mask;
   endfunction : merge

   logic              aw_held_reg, aw_held_next;
   logic [1:0]        aw_sel_reg, aw_sel_next;
   logic              w_held_reg, w_held_next;
   logic [31:0]       wdata_reg, wdata_next;
   logic [3:0]        wstrb_reg, wstrb_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   logic              rvalid_reg, rvalid_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic [15:0]       clk_cfg_reg, clk_cfg_next;
   logic [15:0]       pll_md_reg, pll_md_next;
   logic              do_write;
   // Ready flags registered so every output comes from a flip-flop
   logic              ready_aw_reg, ready_aw_next;
   logic              ready_w_reg, ready_w_next;
   logic              ready_ar_reg, ready_ar_next;

   // Write path: address and data taken in either order, answer after both
   always_comb
   begin
      aw_held_next = aw_held_reg;
      aw_sel_next  = aw_sel_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      clk_cfg_next = clk_cfg_reg;
      pll_md_next  = pll_md_reg;
      do_write     = aw_held_reg && w_held_reg && !bvalid_reg;
      // Take only while ready shows; the first cycle after reset has ready low
      if (s_axi_awvalid && ready_aw_reg)
      begin
         aw_held_next = 1'b1;
         aw_sel_next  = decode(s_axi_awaddr);
      end
      if (s_axi_wvalid && ready_w_reg)
      begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      // Settings land at once; nothing here waits for frame timing
      if (do_write)
      begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = (aw_sel_reg == 2'd0) ? RESP_DECERR : RESP_OKAY;
         if (aw_sel_reg == 2'd1)
            clk_cfg_next = merge(clk_cfg_reg, wdata_reg, wstrb_reg, CLK_CFG_MASK);
         if (aw_sel_reg == 2'd2)
            pll_md_next = merge(pll_md_reg, wdata_reg, wstrb_reg, PLL_MD_MASK);
      end
      if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
   end

   // Read path: one read in flight, data one cycle after the address
   always_comb
   begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rvalid_reg && s_axi_rready)
         rvalid_next = 1'b0;
      if (s_axi_arvalid && ready_ar_reg)
      begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         unique case (decode(s_axi_araddr))
            2'd1:    rdata_next = {16'h0000, clk_cfg_reg};
            2'd2:    rdata_next = {16'h0000, pll_md_reg};
            default:
            begin
               rdata_next = 32'h0000_0000;
               rresp_next = RESP_DECERR;
            end
         endcase
      end
   end

   // Bus and register state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_sel_reg  <= 2'd0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= RESP_OKAY;
         clk_cfg_reg <= CLK_CFG_RESET;
         pll_md_reg  <= PLL_MD_RESET;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         aw_sel_reg  <= aw_sel_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         clk_cfg_reg <= clk_cfg_next;
         pll_md_reg  <= pll_md_next;
      end
   end

   // Ready is the inverse of the held flags in the same cycle, low through reset
   always_comb
   begin
      ready_aw_next = !aw_held_next;
      ready_w_next  = !w_held_next;
      ready_ar_next = !rvalid_next;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ready_aw_reg <= 1'b0;
         ready_w_reg  <= 1'b0;
         ready_ar_reg <= 1'b0;
      end
      else
      begin
         ready_aw_reg <= ready_aw_next;
         ready_w_reg  <= ready_w_next;
         ready_ar_reg <= ready_ar_next;
      end
   end

   // Clock control outputs, one register stage behind the settings
   logic              use_pll_reg, use_pll_next;
   logic              pd_reg, pd_next;
   logic              row_en_reg, row_en_next;
   logic              frame_en_reg, frame_en_next;
   logic              ship_en_reg, ship_en_next;
   logic [MULT_W-1:0] mult_reg, mult_next;
   logic [DIV_W-1:0]  div_reg, div_next;

   always_comb
   begin
      use_pll_next  = !clk_cfg_reg[BIT_PLL_BYPASS];
      // Standby bit is ignored while the PLL is held down anyway
      pd_next       = clk_cfg_reg[BIT_PLL_POWERDOWN]
                      || (standby && clk_cfg_reg[BIT_STANDBY_PD]);
      row_en_next   = row_clk_req || clk_cfg_reg[BIT_FORCE_ROW];
      frame_en_next = frame_clk_req || clk_cfg_reg[BIT_FORCE_FRAME];
      ship_en_next  = ship_clk_req || clk_cfg_reg[BIT_FORCE_SHIP];
      // Values under 16 are passed on unchanged; keeping them legal is software's job
      mult_next     = pll_md_reg[MULT_LSB +: MULT_W];
      div_next      = pll_md_reg[DIV_LSB +: DIV_W];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         use_pll_reg  <= 1'b0;
         pd_reg       <= 1'b1;
         row_en_reg   <= 1'b0;
         frame_en_reg <= 1'b0;
         ship_en_reg  <= 1'b0;
         mult_reg     <= PLL_MD_RESET[MULT_LSB +: MULT_W];
         div_reg      <= PLL_MD_RESET[DIV_LSB +: DIV_W];
      end
      else
      begin
         use_pll_reg  <= use_pll_next;
         pd_reg       <= pd_next;
         row_en_reg   <= row_en_next;
         frame_en_reg <= frame_en_next;
         ship_en_reg  <= ship_en_next;
         mult_reg     <= mult_next;
         div_reg      <= div_next;
      end
   end

   assign s_axi_awready      = ready_aw_reg;
   assign s_axi_wready       = ready_w_reg;
   assign s_axi_bvalid       = bvalid_reg;
   assign s_axi_bresp        = bresp_reg;
   assign s_axi_arready      = ready_ar_reg;
   assign s_axi_rvalid       = rvalid_reg;
   assign s_axi_rdata        = rdata_reg;
   assign s_axi_rresp        = rresp_reg;
   assign master_clk_use_pll = use_pll_reg;
   assign pll_powerdown      = pd_reg;
   assign row_clk_en         = row_en_reg;
   assign frame_clk_en       = frame_en_reg;
   assign ship_clk_en        = ship_en_reg;
   assign pll_multiplier     = mult_reg;
   assign pll_divider        = div_reg;

   // Checks of the clock control behaviour
   sequence s_cfg_write;
      do_write && aw_sel_reg == 2'd1;
   endsequence

   sequence s_md_write;
      do_write && aw_sel_reg == 2'd2;
   endsequence

   a_bypass_select: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 master_clk_use_pll == !$past(clk_cfg_reg[BIT_PLL_BYPASS]))
      else $error("master clock select does not follow bypass bit");
   a_pll_powerdown: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(clk_cfg_reg[BIT_PLL_POWERDOWN]) |-> pll_powerdown)
      else $error("PLL up while power-down bit set");
   a_standby_off: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (!$past(clk_cfg_reg[BIT_PLL_POWERDOWN]) |->
           pll_powerdown == ($past(standby) && $past(clk_cfg_reg[BIT_STANDBY_PD]))))
      else $error("standby power-down handled wrongly");
   a_row_forced: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 row_clk_en == ($past(row_clk_req) || $past(clk_cfg_reg[BIT_FORCE_ROW])))
      else $error("new-row clock enable wrong");
   a_frame_forced: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 frame_clk_en == ($past(frame_clk_req) || $past(clk_cfg_reg[BIT_FORCE_FRAME])))
      else $error("new-frame clock enable wrong");
   a_ship_forced: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 ship_clk_en == ($past(ship_clk_req) || $past(clk_cfg_reg[BIT_FORCE_SHIP])))
      else $error("shipping clock enable wrong");
   a_write_immediate: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_cfg_write and wstrb_reg[1])
      |-> ##2 master_clk_use_pll == !$past(wdata_reg[BIT_PLL_BYPASS], 2))
      else $error("clock write did not reach the select in two cycles");
   a_pll_md_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_md_write and wstrb_reg[0])
      |-> ##2 pll_divider == $past(wdata_reg[DIV_W-1:0], 2))
      else $error("divider write did not take effect in two cycles");

endmodule : spc_clock_control

// ---- verification/spc_clock_control_test.sv ----
/*
   Self-checking bench of the master-clock and PLL control block.
   Assumes the block answers on AXI4-Lite and that its clock outputs follow
   the register bits one cycle after the write lands.
*/
module spc_clock_control_test
   import spc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed
   {
      logic [15:0] d;
      logic        sb;
      logic [2:0]  req;
      logic [15:0] rd;
      logic [4:0]  outs;
   } spc_row_type;

   // Stimulus and observation signals
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic        standby = 1'b0;
   logic [2:0]  req = 3'b000;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, rd;
   logic [1:0]  resp;
   logic        use_pll, pd, row_en, frame_en, ship_en;
   logic [7:0]  mult;
   logic [5:0]  div;
   logic [31:0] outs_seen, md_seen;
   int          err_count = 0;
   int          check_count = 0;

   // Rows: written value, standby, gate requests, read-back, {use_pll,pd,row,frame,ship}
   spc_row_type rows [11] = '{
      '{16'hE000, 1'b0, 3'b000, 16'hE000, 5'b01000},
      '{16'h6000, 1'b0, 3'b000, 16'h6000, 5'b11000},
      '{16'h2000, 1'b1, 3'b000, 16'h2000, 5'b11000},
      '{16'h2000, 1'b0, 3'b000, 16'h2000, 5'b10000},
      '{16'h0000, 1'b1, 3'b000, 16'h0000, 5'b10000},
      '{16'h0004, 1'b0, 3'b000, 16'h0004, 5'b10100},
      '{16'h0002, 1'b0, 3'b100, 16'h0002, 5'b10110},
      '{16'h0001, 1'b0, 3'b000, 16'h0001, 5'b10001},
      '{16'h1FF8, 1'b1, 3'b111, 16'h0000, 5'b10111},
      '{16'hC000, 1'b1, 3'b000, 16'hC000, 5'b01000},
      '{16'hA005, 1'b1, 3'b010, 16'hA005, 5'b01111}
   };

   always #5 aclk = ~aclk;

   // Outputs gathered as {use_pll,pd,row,frame,ship} and in register layout
   assign outs_seen = {27'h0, use_pll, pd, row_en, frame_en, ship_en};
   assign md_seen   = {16'h0000, mult, 2'b00, div};

   spc_clock_control uut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .standby(standby), .row_clk_req(req[2]), .frame_clk_req(req[1]),
      .ship_clk_req(req[0]), .master_clk_use_pll(use_pll), .pll_powerdown(pd),
      .row_clk_en(row_en), .frame_clk_en(frame_en), .ship_clk_en(ship_en),
      .pll_multiplier(mult), .pll_divider(div)
   );

   task automatic end_of_test;
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : check

   // Address and data offered together; each released once taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge aclk);
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      awaddr <= a; wdata <= d; wstrb <= s;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50)
      begin
         err_count++;
         end_of_test();
      end
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a);
      int n;
      @(posedge aclk);
      arvalid <= 1'b1; rready <= 1'b1; araddr <= a;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50)
      begin
         err_count++;
         end_of_test();
      end
   endtask : axi_read

   // Outputs settle a cycle after the write; sampled clear of the edge
   task automatic settle;
      repeat (2) @(posedge aclk);
      #1;
   endtask : settle

   // Reset defaults of outputs and both registers
   task automatic check_defaults;
      check("clk_outs", 32'h0000_0008, outs_seen);
      check("mult_div", 32'h0000_2809, md_seen);
      axi_read(ADDR_MASTER_CLOCK_CONFIG);
      check("clk_reg", 32'h0000_E000, rd);
      axi_read(ADDR_PLL_MULT_DIV);
      check("pll_reg", 32'h0000_2809, rd);
   endtask : check_defaults

   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      check_defaults();
      // Table of clock-select, power-down and gate cases
      foreach (rows[i])
      begin
         @(posedge aclk);
         standby <= rows[i].sb;
         req <= rows[i].req;
         axi_write(ADDR_MASTER_CLOCK_CONFIG, {16'h0000, rows[i].d}, 4'h3);
         check("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
         settle();
         check("clk_outs", 32'(rows[i].outs), outs_seen);
         axi_read(ADDR_MASTER_CLOCK_CONFIG);
         check("clk_reg", {16'h0000, rows[i].rd}, rd);
         check("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      end
      // Multiplier and divider, reserved bits, smallest legal multiplier, one strobe
      axi_write(ADDR_PLL_MULT_DIV, 32'hFFFF_10C5, 4'hF);
      settle();
      check("mult_div", 32'h0000_1005, md_seen);
      axi_read(ADDR_PLL_MULT_DIV);
      check("pll_reg", 32'h0000_1005, rd);
      axi_write(ADDR_PLL_MULT_DIV, 32'h0000_103F, 4'h3);
      axi_write(ADDR_PLL_MULT_DIV, 32'h0000_AAAA, 4'h1);
      settle();
      check("mult_div", 32'h0000_102A, md_seen);
      // Unmapped place: refused, no effect
      axi_write(12'h000, 32'h0000_FFFF, 4'hF);
      check("bresp", {30'h0, RESP_DECERR}, {30'h0, resp});
      axi_read(12'h000);
      check("rresp", {30'h0, RESP_DECERR}, {30'h0, resp});
      check("rdata", 32'h0000_0000, rd);
      axi_read(ADDR_MASTER_CLOCK_CONFIG);
      check("clk_reg", 32'h0000_A005, rd);
      // Second reset in mid-run restores every default
      @(posedge aclk);
      standby <= 1'b0;
      req <= 3'b000;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      check_defaults();
      end_of_test();
   end
endmodule : spc_clock_control_test
